// [hdl/cdbs_pkg.sv]
// Purpose: Constants and carrier types for the processor data bus steering block
// Assumes: 50 MHz system clock, synchronous active-high reset
// Notes: All timing and decode figures live here
`default_nettype none
package cdbs_pkg;
    // Dot clock is 14.31818 MHz; the sync clock runs at a ninth of it
    localparam int DOT_CLOCK_HZ = 14318180;
    localparam int SYS_CLOCK_HZ = 50000000;
    localparam int DOT_DIV = 9;
    // System cycles per sync period, rounded down
    localparam int SYNC_CYCLES = int'((64'(SYS_CLOCK_HZ) * DOT_DIV) / DOT_CLOCK_HZ);
    localparam int PHASE1_END = 1;
    localparam int PHASE2_BEGIN = 2;
    localparam int PHASE2_END = 5;
    localparam logic [5:0] PAGE_ROM0 = 6'h30;
    localparam logic [5:0] PAGE_ROM1 = 6'h31;
    localparam logic [5:0] PAGE_SRAM = 6'h32;
    localparam logic [5:0] PAGE_VRAM = 6'h33;
    localparam logic [5:0] PAGE_ZERO = 6'h00;
    localparam logic [7:0] PORT_SERIAL_DATA = 8'hF9;
    localparam logic [7:0] PORT_SERIAL_STAT = 8'hF8;
    localparam logic [7:0] PORT_CASS_DATA = 8'hFB;
    localparam logic [7:0] PORT_CASS_STAT = 8'hFA;
    localparam logic [7:0] PORT_KEYBOARD = 8'hFC;
    localparam logic [7:0] PORT_PARALLEL = 8'hFD;
    localparam logic [7:0] PORT_SENSE = 8'hFF;
    typedef enum logic [1:0] {
        CDBS_SRC_KBD = 2'b00,
        CDBS_SRC_PAR = 2'b01,
        CDBS_SRC_SHARED = 2'b10,
        CDBS_SRC_INT = 2'b11
    } cdbs_src_t;
    typedef struct packed {
        logic is_mem;
        logic is_io;
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [7:0] status;
        logic [5:0] cmd;
    } cdbs_cpu_t;
    typedef struct packed {
        logic rom_sel;
        logic sram_sel;
        logic vram_sel;
        logic serial_sel;
        logic cass_sel;
        logic kbd_sel;
        logic par_sel;
        logic sense_sel;
    } cdbs_sel_t;
endpackage
`default_nettype wire

// [hdl/cdbs_steering.sv]
// Purpose: Data steering and bus buffering around the processor core
// Assumes: Control inputs from off-chip pass a 3-stage filter on the sync tick
// Notes: Tri-state lines are split into out and enable; the shared data lines also have an in
`default_nettype none
module cdbs_steering (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire cdbs_pkg::cdbs_cpu_t cpu_i,
    input wire logic [7:0] kbd_data_i,
    input wire logic [7:0] par_data_i,
    input wire logic [7:0] internal_bus_i,
    input wire logic [7:0] shared_data_lines_i,
    input wire logic [7:0] sense_switch_i,
    input wire logic [3:0] dma_disable_n_i,
    input wire logic page_zero_jumper_i,
    input wire logic wait_mem_i,
    input wire logic wait_ext_i,
    input wire logic [2:0] ctrl_in_i,
    output logic [7:0] cpu_rdata_o,
    output logic cpu_wait_o,
    output logic [2:0] cpu_ctrl_o,
    output logic [7:0] shared_data_lines_o,
    output logic shared_data_oe_o,
    output logic [15:0] addr_o,
    output logic addr_oe_o,
    output logic [7:0] status_o,
    output logic status_oe_o,
    output logic [5:0] cmd_o,
    output logic cmd_oe_o,
    output logic page_zero_disable_o,
    output logic sense_drive_o,
    output cdbs_pkg::cdbs_sel_t sel_o,
    output logic phase1_o,
    output logic phase2_o,
    output logic sync_clock_o
);
    logic [7:0] sync_cnt;
    logic sync_tick;
    logic [2:0] wm_sh;
    logic [2:0] we_sh;
    logic [2:0] c0_sh;
    logic [2:0] c1_sh;
    logic [2:0] c2_sh;
    logic [2:0] dma_sh [4];
    logic wait_mem_f;
    logic wait_ext_f;
    logic [3:0] dma_off_f;
    logic [2:0] ctrl_f;
    cdbs_pkg::cdbs_sel_t next_sel;
    cdbs_pkg::cdbs_src_t next_src;
    logic bus_owned;
    logic read_strobe;

    // Takes the last stage when the two late stages agree, else keeps the old value
    function automatic logic agreed(input logic [2:0] sh, input logic old);
        agreed = (sh[1] == sh[2]) ? sh[2] : old;
    endfunction

    // Sync clock and two phase clocks from one counter
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || sync_cnt == 8'(cdbs_pkg::SYNC_CYCLES - 1)) begin
            sync_cnt <= 8'h00;
        end else begin
            sync_cnt <= sync_cnt + 8'h01;
        end
    end
    assign sync_tick = (sync_cnt == 8'h00) && !reset_i;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            phase1_o <= 1'b0;
            phase2_o <= 1'b0;
            sync_clock_o <= 1'b0;
        end else begin
            // Gap cycles keep the phases from overlapping
            phase1_o <= (sync_cnt < 8'(cdbs_pkg::PHASE1_END));
            phase2_o <= (sync_cnt >= 8'(cdbs_pkg::PHASE2_BEGIN))
                && (sync_cnt < 8'(cdbs_pkg::PHASE2_END));
            sync_clock_o <= sync_tick;
        end
    end

    // Off-chip control inputs are shifted in on every system clock
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wm_sh <= 3'h0;
            we_sh <= 3'h0;
            c0_sh <= 3'h0;
            c1_sh <= 3'h0;
            c2_sh <= 3'h0;
            for (int i = 0; i < 4; i++) begin
                dma_sh[i] <= 3'h7;
            end
        end else begin
            wm_sh <= {wm_sh[1:0], wait_mem_i};
            we_sh <= {we_sh[1:0], wait_ext_i};
            c0_sh <= {c0_sh[1:0], ctrl_in_i[0]};
            c1_sh <= {c1_sh[1:0], ctrl_in_i[1]};
            c2_sh <= {c2_sh[1:0], ctrl_in_i[2]};
            for (int i = 0; i < 4; i++) begin
                dma_sh[i] <= {dma_sh[i][1:0], dma_disable_n_i[i]};
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            wait_mem_f <= 1'b0;
            wait_ext_f <= 1'b0;
            ctrl_f <= 3'h0;
            dma_off_f <= 4'h0;
        end else if (sync_tick) begin
            wait_mem_f <= agreed(wm_sh, wait_mem_f);
            wait_ext_f <= agreed(we_sh, wait_ext_f);
            ctrl_f <= {agreed(c2_sh, ctrl_f[2]), agreed(c1_sh, ctrl_f[1]),
                agreed(c0_sh, ctrl_f[0])};
            for (int i = 0; i < 4; i++) begin
                dma_off_f[i] <= !agreed(dma_sh[i], !dma_off_f[i]);
            end
        end
    end

    // Any DMA disable hands the bus away; the DMA master drives it
    assign bus_owned = (dma_off_f == 4'h0);
    assign read_strobe = cpu_i.rd;

    // Page and port decode
    always_comb begin
        next_sel = '0;
        next_src = cdbs_pkg::CDBS_SRC_SHARED; // Default lets external parts answer
        if (cpu_i.is_mem) begin
            next_sel.rom_sel = (cpu_i.addr[15:10] == cdbs_pkg::PAGE_ROM0)
                || (cpu_i.addr[15:10] == cdbs_pkg::PAGE_ROM1);
            next_sel.sram_sel = (cpu_i.addr[15:10] == cdbs_pkg::PAGE_SRAM);
            next_sel.vram_sel = (cpu_i.addr[15:10] == cdbs_pkg::PAGE_VRAM);
            // ROM and system RAM answer on internal bus; display RAM does not
            if (cpu_i.rd && (next_sel.rom_sel || next_sel.sram_sel)) begin
                next_src = cdbs_pkg::CDBS_SRC_INT;
            end
        end else if (cpu_i.is_io) begin
            case (cpu_i.addr[15:8])
                cdbs_pkg::PORT_SERIAL_DATA, cdbs_pkg::PORT_SERIAL_STAT: begin
                    next_sel.serial_sel = 1'b1;
                    next_src = cdbs_pkg::CDBS_SRC_INT; // UARTs drive it directly
                end
                cdbs_pkg::PORT_CASS_DATA, cdbs_pkg::PORT_CASS_STAT: begin
                    next_sel.cass_sel = 1'b1;
                    next_src = cdbs_pkg::CDBS_SRC_INT;
                end
                cdbs_pkg::PORT_KEYBOARD: begin
                    next_sel.kbd_sel = 1'b1;
                    next_src = cdbs_pkg::CDBS_SRC_KBD;
                end
                cdbs_pkg::PORT_PARALLEL: begin
                    next_sel.par_sel = 1'b1;
                    next_src = cdbs_pkg::CDBS_SRC_PAR;
                end
                cdbs_pkg::PORT_SENSE: begin
                    next_sel.sense_sel = 1'b1;
                    next_src = cdbs_pkg::CDBS_SRC_SHARED; // Switches sit on shared bus
                end
                default: begin
                    next_src = cdbs_pkg::CDBS_SRC_SHARED;
                end
            endcase
        end
    end

    // Four-way input selector, registered
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cpu_rdata_o <= 8'h00;
        end else begin
            case (next_src)
                cdbs_pkg::CDBS_SRC_KBD: cpu_rdata_o <= kbd_data_i;
                cdbs_pkg::CDBS_SRC_PAR: cpu_rdata_o <= par_data_i;
                cdbs_pkg::CDBS_SRC_INT: cpu_rdata_o <= internal_bus_i;
                cdbs_pkg::CDBS_SRC_SHARED: cpu_rdata_o <= next_sel.sense_sel
                    ? sense_switch_i : shared_data_lines_i;
                default: cpu_rdata_o <= shared_data_lines_i;
            endcase
        end
    end

    // Selects and sense switch drive
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sel_o <= '0;
            sense_drive_o <= 1'b0;
        end else begin
            sel_o <= next_sel;
            sense_drive_o <= next_sel.sense_sel && cpu_i.rd;
        end
    end

    // Processor-side tri-state drivers
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            shared_data_lines_o <= 8'h00;
            shared_data_oe_o <= 1'b0;
            addr_o <= 16'h0000;
            addr_oe_o <= 1'b0;
            status_o <= 8'h00;
            status_oe_o <= 1'b0;
            cmd_o <= 6'h00;
            cmd_oe_o <= 1'b0;
        end else begin
            shared_data_lines_o <= cpu_i.wdata;
            // All writes while the bus is owned, on-board RAM included, go out here
            shared_data_oe_o <= bus_owned && cpu_i.wr && !cpu_i.rd;
            addr_o <= cpu_i.addr;
            addr_oe_o <= bus_owned;
            status_o <= cpu_i.status;
            status_oe_o <= bus_owned;
            cmd_o <= cpu_i.cmd;
            cmd_oe_o <= bus_owned;
        end
    end

    // Page-zero disable follows the read strobe when jumpered
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            page_zero_disable_o <= 1'b0;
        end else begin
            page_zero_disable_o <= page_zero_jumper_i && read_strobe
                && cpu_i.is_mem && (cpu_i.addr[15:10] == cdbs_pkg::PAGE_ZERO);
        end
    end

    // Either wait request stretches the cycle control inputs forwarded
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cpu_wait_o <= 1'b0;
            cpu_ctrl_o <= 3'h0;
        end else begin
            cpu_wait_o <= wait_mem_f || wait_ext_f;
            cpu_ctrl_o <= ctrl_f;
        end
    end

    a_wait_follows: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (wait_mem_f || wait_ext_f) |=> cpu_wait_o)
        else $error("wait request not passed to processor");
    a_dma_release: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (dma_off_f != 4'h0) |=> !addr_oe_o && !shared_data_oe_o && !cmd_oe_o)
        else $error("drivers on while bus is lent");
    a_int_source: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (cpu_i.is_mem && cpu_i.rd && cpu_i.addr[15:10] == cdbs_pkg::PAGE_SRAM)
        |=> cpu_rdata_o == $past(internal_bus_i))
        else $error("system RAM read not from internal bus");
    a_vram_shared: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (cpu_i.is_mem && cpu_i.addr[15:10] == cdbs_pkg::PAGE_VRAM)
        |=> cpu_rdata_o == $past(shared_data_lines_i) && sel_o.vram_sel)
        else $error("display RAM read path wrong");
    a_kbd_source: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (cpu_i.is_io && cpu_i.addr[15:8] == cdbs_pkg::PORT_KEYBOARD)
        |=> cpu_rdata_o == $past(kbd_data_i))
        else $error("keyboard port not selected");
    a_sense_path: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (cpu_i.is_io && cpu_i.rd && cpu_i.addr[15:8] == cdbs_pkg::PORT_SENSE)
        |=> sense_drive_o && cpu_rdata_o == $past(sense_switch_i))
        else $error("sense switches not read over shared bus");
    a_page_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        page_zero_disable_o |-> $past(page_zero_jumper_i) && $past(cpu_i.addr[15:10]) == 6'h00)
        else $error("page-zero disable without cause");
    a_write_drive: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (bus_owned && cpu_i.wr && !cpu_i.rd) |=> shared_data_oe_o
        && shared_data_lines_o == $past(cpu_i.wdata))
        else $error("write data not on shared bus");
    a_phase_apart: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !(phase1_o && phase2_o))
        else $error("phase clocks overlap");
    a_rom_internal: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (cpu_i.is_mem && cpu_i.rd && (cpu_i.addr[15:10] == cdbs_pkg::PAGE_ROM0
        || cpu_i.addr[15:10] == cdbs_pkg::PAGE_ROM1))
        |=> cpu_rdata_o == $past(internal_bus_i) && sel_o.rom_sel)
        else $error("ROM read not from internal bus");
    a_uart_internal: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (cpu_i.is_io && (cpu_i.addr[15:8] == cdbs_pkg::PORT_SERIAL_DATA
        || cpu_i.addr[15:8] == cdbs_pkg::PORT_CASS_DATA))
        |=> cpu_rdata_o == $past(internal_bus_i) && (sel_o.serial_sel || sel_o.cass_sel))
        else $error("UART read not from internal bus");
    a_par_source: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (cpu_i.is_io && cpu_i.addr[15:8] == cdbs_pkg::PORT_PARALLEL)
        |=> cpu_rdata_o == $past(par_data_i) && sel_o.par_sel)
        else $error("parallel port not selected");
    a_mem_default: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (cpu_i.is_mem && cpu_i.addr[15:12] != 4'hC)
        |=> cpu_rdata_o == $past(shared_data_lines_i) && sel_o == '0)
        else $error("unclaimed memory read not from shared bus");
    a_io_default: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (cpu_i.is_io && cpu_i.addr[15:11] != 5'h1F)
        |=> cpu_rdata_o == $past(shared_data_lines_i) && sel_o == '0)
        else $error("unclaimed port read not from shared bus");
    a_status_drive: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        bus_owned |=> status_oe_o && cmd_oe_o && status_o == $past(cpu_i.status)
        && cmd_o == $past(cpu_i.cmd))
        else $error("status or command lines not driven");
    a_addr_drive: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        bus_owned |=> addr_oe_o && addr_o == $past(cpu_i.addr))
        else $error("address lines not driven");
    a_read_no_drive: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cpu_i.rd |=> !shared_data_oe_o)
        else $error("shared bus driven during a read");
    a_pz_fires: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (page_zero_jumper_i && cpu_i.rd && cpu_i.is_mem
        && cpu_i.addr[15:10] == cdbs_pkg::PAGE_ZERO) |=> page_zero_disable_o)
        else $error("page-zero disable missing");
    a_wait_release: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !(wait_mem_f || wait_ext_f) |=> !cpu_wait_o)
        else $error("wait held with no request");
    a_sel_onehot: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $onehot0(sel_o))
        else $error("more than one select active");
    a_ram_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (bus_owned && cpu_i.is_mem && cpu_i.wr && !cpu_i.rd
        && (cpu_i.addr[15:10] == cdbs_pkg::PAGE_SRAM
        || cpu_i.addr[15:10] == cdbs_pkg::PAGE_VRAM)) |=> shared_data_oe_o)
        else $error("RAM write not on shared bus");
endmodule
`default_nettype wire

// [tb/cdbs_far_model.sv]
// Purpose: Far-side model of on-board memory, UARTs and external bus modules
// Assumes: Answers combinationally from the processor request
// Notes: Undriven lines show a moving pattern, never a stale value
`default_nettype none
module cdbs_far_model (
    input wire logic clk_sys_i,
    input wire cdbs_pkg::cdbs_cpu_t cpu_i,
    output logic [7:0] internal_bus_o,
    output logic [7:0] shared_bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] junk = 8'h00;
    logic int_mem;
    logic on_io;
    // Floating lines keep changing so a stale byte cannot pass
    always_ff @(posedge clk_sys_i) begin
        junk <= junk + 8'h3B;
    end
    assign int_mem = cpu_i.is_mem && cpu_i.addr[15:12] == 4'hC && cpu_i.addr[11:10] != 2'h3;
    assign on_io = cpu_i.is_io && cpu_i.addr[15:11] == 5'h1F && cpu_i.addr[10:8] != 3'h6;
    // ROM, system RAM and both UARTs; display RAM stays off this bus
    always_comb begin
        internal_bus_o = ~junk;
        if (cpu_i.rd && int_mem) begin
            internal_bus_o = cpu_i.addr[7:0] ^ 8'h5A;
        end else if (cpu_i.rd && on_io && !cpu_i.addr[10]) begin
            internal_bus_o = {4'hA, cpu_i.addr[11:8]};
        end
    end
    // External modules and display RAM answer on the shared bus
    always_comb begin
        shared_bus_o = junk;
        if (cpu_i.rd && !int_mem && !on_io) begin
            shared_bus_o = cpu_i.addr[7:0] ^ 8'hC3;
        end
    end
endmodule
`default_nettype wire

// [tb/tb_cpu_data_bus_steering.sv]
// Purpose: Self-checking bench for the data steering block
// Assumes: Inputs change on the falling edge and are held two cycles
// Notes: Filtered inputs are awaited under a bound of 80 cycles
`default_nettype none
module tb_cpu_data_bus_steering;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    cdbs_pkg::cdbs_cpu_t cpu_i = '0;
    logic [7:0] kbd_data_i = 8'h4B;
    logic [7:0] par_data_i = 8'h2D;
    logic [7:0] sense_switch_i = 8'h96;
    logic [3:0] dma_disable_n_i = 4'hF;
    logic page_zero_jumper_i = 1'b0;
    logic wait_mem_i = 1'b0;
    logic wait_ext_i = 1'b0;
    logic [2:0] ctrl_in_i = 3'h0;
    logic [7:0] internal_bus, shared_model, shared_in, cpu_rdata_o, shared_data_lines_o, status_o;
    logic cpu_wait_o, shared_data_oe_o, addr_oe_o, status_oe_o, cmd_oe_o, page_zero_disable_o;
    logic sense_drive_o, phase1_o, phase2_o, sync_clock_o;
    logic [2:0] cpu_ctrl_o;
    logic [15:0] addr_o;
    logic [5:0] cmd_o;
    cdbs_pkg::cdbs_sel_t sel_o;
    int error_cnt = 0;
    int tests_run = 0;
    initial forever #10 clk_sys_i = ~clk_sys_i;
    // Wire level of the two-way bus seen by the block
    assign shared_in = shared_data_oe_o ? shared_data_lines_o : shared_model;
    cdbs_far_model u_cdbs_far_model (.clk_sys_i, .cpu_i, .internal_bus_o(internal_bus),
        .shared_bus_o(shared_model));
    cdbs_steering u_cdbs_steering (.clk_sys_i, .reset_i, .cpu_i, .kbd_data_i, .par_data_i,
        .internal_bus_i(internal_bus), .shared_data_lines_i(shared_in), .sense_switch_i,
        .dma_disable_n_i, .page_zero_jumper_i, .wait_mem_i, .wait_ext_i, .ctrl_in_i,
        .cpu_rdata_o, .cpu_wait_o, .cpu_ctrl_o, .shared_data_lines_o, .shared_data_oe_o,
        .addr_o, .addr_oe_o, .status_o, .status_oe_o, .cmd_o, .cmd_oe_o, .page_zero_disable_o,
        .sense_drive_o, .sel_o, .phase1_o, .phase2_o, .sync_clock_o);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    function automatic logic pick(input int w);
        return (w == 0) ? addr_oe_o : (w == 1) ? cpu_wait_o : sync_clock_o;
    endfunction
    task automatic wait_until(input int w, input logic v);
        for (int i = 0; i < 80 && pick(w) !== v; i++) begin
            @(negedge clk_sys_i);
        end
        if (pick(w) !== v) begin
            check(16'(pick(w)), 16'(v));
            end_sim();
        end
    endtask
    // The status byte follows the data so each request is distinct; the command byte is fixed at 6'h2A
    task automatic req(input logic m, input logic r, input logic [15:0] a, input logic [7:0] d);
        cpu_i = '{m, !m, r, !r, a, d, 8'hA5 ^ d, 6'h2A};
        repeat (2) @(negedge clk_sys_i);
    endtask
    task automatic t_mem();
        logic [15:0] a [8] = '{16'hC000, 16'hC7FF, 16'hC800, 16'hCBFF, 16'hCC00, 16'hCFFF,
            16'h8000, 16'hBFFF};
        logic [2:0] s [8] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};
        for (int i = 0; i < 8; i++) begin
            req(1'b1, 1'b1, a[i], 8'h00);
            check(16'(cpu_rdata_o),
                16'(a[i][7:0] ^ (i < 4 ? 8'h5A : 8'hC3)));
            check(16'({sel_o.rom_sel, sel_o.sram_sel, sel_o.vram_sel}),
                16'(s[i]));
            check(16'(shared_data_oe_o), 16'h0000);
        end
        $display("test mem_read done");
    endtask
    task automatic t_io();
        logic [7:0] p [8] = '{8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFF, 8'h10};
        logic [7:0] e [8] = '{8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'h4B, 8'h2D, 8'h96, 8'hD3};
        logic [4:0] s [8] = '{5'h10, 5'h10, 5'h08, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00};
        for (int i = 0; i < 8; i++) begin
            req(1'b0, 1'b1, {p[i], p[i]}, 8'h00);
            check(16'(cpu_rdata_o), 16'(e[i]));
            check(16'({sel_o.serial_sel, sel_o.cass_sel, sel_o.kbd_sel, sel_o.par_sel,
                sel_o.sense_sel}), 16'(s[i]));
            check(16'(sense_drive_o), 16'(i == 6));
        end
        $display("test io_read done");
    endtask
    task automatic t_write();
        req(1'b1, 1'b0, 16'hC812, 8'h3C);
        check({shared_data_lines_o, status_o}, 16'h3C99);
        check(addr_o, 16'hC812);
        check(16'({cmd_o, shared_data_oe_o, addr_oe_o, status_oe_o, cmd_oe_o}),
            16'h02AF);
        req(1'b0, 1'b0, 16'hFDFD, 8'hC1);
        check({shared_data_lines_o, 7'h00, shared_data_oe_o}, 16'hC101);
        $display("test write done");
    endtask
    task automatic t_dma();
        logic [3:0] pat [4] = '{4'hE, 4'hD, 4'hB, 4'h7};
        req(1'b1, 1'b0, 16'h4000, 8'h55);
        for (int i = 0; i < 4; i++) begin
            dma_disable_n_i = pat[i];
            wait_until(0, 1'b0);
            check(16'({shared_data_oe_o, status_oe_o, cmd_oe_o}), 16'h0000);
            dma_disable_n_i = 4'hF;
            wait_until(0, 1'b1);
            check(16'(shared_data_oe_o), 16'h0001);
        end
        $display("test dma done");
    endtask
    task automatic t_pz();
        page_zero_jumper_i = 1'b1;
        req(1'b1, 1'b1, 16'h0123, 8'h00);
        check(16'(page_zero_disable_o), 16'h0001);
        req(1'b1, 1'b1, 16'h0423, 8'h00);
        check(16'(page_zero_disable_o), 16'h0000);
        page_zero_jumper_i = 1'b0;
        req(1'b1, 1'b1, 16'h0123, 8'h00);
        check(16'(page_zero_disable_o), 16'h0000);
        $display("test page_zero done");
    endtask
    task automatic t_wait();
        for (int k = 0; k < 2; k++) begin
            {wait_ext_i, wait_mem_i} = k ? 2'b10 : 2'b01;
            ctrl_in_i = k ? 3'h5 : 3'h2;
            wait_until(1, 1'b1);
            repeat (2) @(negedge clk_sys_i);
            check(16'(cpu_ctrl_o), 16'(ctrl_in_i));
            {wait_ext_i, wait_mem_i} = 2'b00;
            wait_until(1, 1'b0);
        end
        $display("test wait done");
    endtask
    task automatic t_clk();
        int n = 0;
        int p1 = 0;
        int p2 = 0;
        int ov = 0;
        wait_until(2, 1'b1);
        do begin
            p1 += int'(phase1_o === 1'b1);
            p2 += int'(phase2_o === 1'b1);
            ov += int'(phase1_o === 1'b1 && phase2_o === 1'b1);
            @(negedge clk_sys_i);
            n++;
        end while (sync_clock_o !== 1'b1 && n < 100);
        check(16'(n), 16'(cdbs_pkg::SYNC_CYCLES));
        check(16'(p1), 16'(cdbs_pkg::PHASE1_END));
        check(16'(p2), 16'(cdbs_pkg::PHASE2_END - cdbs_pkg::PHASE2_BEGIN));
        check(16'(ov), 16'h0000);
        $display("test clocks done");
    endtask
    initial begin
        repeat (8) @(negedge clk_sys_i);
        // Enables stay off while reset is held
        check(16'({shared_data_oe_o, addr_oe_o, status_oe_o, cmd_oe_o}), 16'h0000);
        reset_i = 1'b0;
        t_mem();
        t_io();
        t_write();
        t_dma();
        t_pz();
        t_wait();
        t_clk();
        end_sim();
    end
endmodule
`default_nettype wire
